// ### pkg/reload_timer_pkg.sv
// Shared constants for the three-channel reload down timer.
package reload_timer_pkg;
  localparam int ADDR_W      = 6;
  localparam int DATA_W      = 16;
  localparam int CNT_W       = 32;
  localparam int NUM_CH      = 3;
  localparam int PRESCALE_N  = 5;
  localparam int PDIV_W      = 2 * PRESCALE_N;

  // Register indexes on the 16-bit register port.
  localparam logic [ADDR_W-1:0] PIN_CTRL_IDX = 6'h00;
  localparam logic [ADDR_W-1:0] RUN_CTRL_IDX = 6'h01;
  localparam logic [ADDR_W-1:0] CH_BASE_IDX  = 6'h08;
  localparam logic [2:0]        RELOAD_LO_OFS = 3'h0;
  localparam logic [2:0]        RELOAD_HI_OFS = 3'h1;
  localparam logic [2:0]        COUNT_LO_OFS  = 3'h2;
  localparam logic [2:0]        COUNT_HI_OFS  = 3'h3;
  localparam logic [2:0]        CONTROL_OFS   = 3'h4;

  // Field positions.
  localparam int PIN_OUT_BIT   = 0;
  localparam int FLAG_BIT      = 8;
  localparam int CAP_CTRL_LSB  = 6;
  localparam int IRQ_EN_BIT    = 5;
  localparam int EDGE_LSB      = 3;
  localparam int PRESCALE_LSB  = 0;
  localparam int CAP_CH        = 2;

  // Reset values.
  localparam logic             PIN_CTRL_RST = 1'h0;
  localparam logic [2:0]       RUN_CTRL_RST = 3'h0;
  localparam logic [CNT_W-1:0] RELOAD_RST   = 32'h0FFFFFFF;
  localparam logic [CNT_W-1:0] COUNT_RST    = 32'h0FFFFFFF;
  localparam logic [2:0]       PRESCALE_RST = 3'h0;
  localparam logic [1:0]       EDGE_RST     = 2'h0;
  localparam logic [1:0]       CAP_CTRL_RST = 2'h0;

  // Count clock codes.
  localparam logic [2:0] PS_DIV1024 = 3'h4;
  localparam logic [2:0] PS_RTC     = 3'h6;
  localparam logic [2:0] PS_PIN     = 3'h7;

  // Edge codes; any code with the high bit set counts both edges.
  localparam logic [1:0] EDGE_RISE  = 2'h0;
  localparam logic [1:0] EDGE_FALL  = 2'h1;
endpackage : reload_timer_pkg

// ### design/count_source_select.sv
// Per-channel choice of the count clock event.
`timescale 1ns/1ns
module count_source_select
  import reload_timer_pkg::*;
(
  input  wire logic [2:0]            i_prescale,
  input  wire logic [1:0]            i_edge,
  input  wire logic [PRESCALE_N-1:0] i_div_tick,
  input  wire logic                  i_rtc_rise,
  input  wire logic                  i_pin_rise,
  input  wire logic                  i_pin_fall,
  input  wire logic                  i_standby,
  output logic                       o_count_event,
  output logic                       o_is_rtc
);
  logic pin_event;

  // Edge choice for the pin clock; the high code bit selects both edges.
  always_comb begin
    if (i_edge[1]) begin
      pin_event = i_pin_rise | i_pin_fall;
    end else if (i_edge == EDGE_FALL) begin
      pin_event = i_pin_fall;
    end else begin
      pin_event = i_pin_rise;
    end
  end

  // Only the tick source survives standby, because the timer's own clock is stopped then.
  always_comb begin
    o_is_rtc = (i_prescale == PS_RTC);
    if (o_is_rtc) begin
      o_count_event = i_rtc_rise;
    end else if (i_standby) begin
      o_count_event = 1'b0;
    end else if (i_prescale == PS_PIN) begin
      o_count_event = pin_event;
    end else if (i_prescale <= PS_DIV1024) begin
      o_count_event = i_div_tick[i_prescale];
    end else begin
      o_count_event = 1'b0;
    end
  end
endmodule : count_source_select

// ### design/reload_down_timer.sv
// Three-channel auto-reload down timer with register port and shared clock pin.
`timescale 1ns/1ns
// How it works
// - Unused pin and run bits read zero
// - Pin bit zero: input, one: drive tick
// - Pin control resets zero, kept in standby
// - Run bit per channel enables counting
// - Run resets zero; standby clears non-tick channels
// - Underflow loads the reload constant
// - Reload constants reset, kept in standby
// - Counter decrements on selected count clock
// - Underflow sets flag while loading constant
// - Upper read buffers lower half coherently
// - Counters reset; non-tick counters kept in standby
// - Tick channels keep counting in standby
// - Sixteen-bit control resets zero, kept
// - Flag 8, enable 5, edge 4:3, prescale 2:0
// - Channel two adds capture control bits
// - Flag cleared only by writing zero
// - Interrupt while flag and enable set
// - Prescale codes pick divider, tick, pin
// - Edge select rise, fall or both
module reload_down_timer
  import reload_timer_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_reset,
  input  wire logic              i_standby,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_write,
  input  wire logic              i_read,
  output logic      [DATA_W-1:0] o_rdata,
  input  wire logic              i_rtc_tick,
  input  wire logic              i_clk_pin_in,
  output logic                   o_clk_pin_out,
  output logic                   o_clk_pin_oe,
  output logic      [NUM_CH-1:0] o_underflow_interrupt
);
  // Selects one channel's register group.
  function automatic logic chan_sel(input logic [ADDR_W-1:0] a, input logic [2:0] ch);
    return a[ADDR_W-1:3] == CH_BASE_IDX[ADDR_W-1:3] + ch;
  endfunction : chan_sel

  logic                  pin_out_sel;
  logic [NUM_CH-1:0]     run;
  logic [CNT_W-1:0]      count     [NUM_CH];
  logic [CNT_W-1:0]      reload    [NUM_CH];
  logic [DATA_W-1:0]     low_buf   [NUM_CH];
  logic [2:0]            prescale  [NUM_CH];
  logic [1:0]            edge_sel  [NUM_CH];
  logic [NUM_CH-1:0]     irq_en;
  logic [NUM_CH-1:0]     flag;
  logic [1:0]            cap_ctrl;
  logic [NUM_CH-1:0]     count_event;
  logic [NUM_CH-1:0]     is_rtc;
  logic [NUM_CH-1:0]     underflow;
  logic [PDIV_W-1:0]     pdiv;
  logic [PRESCALE_N-1:0] div_tick;
  logic                  rtc_prev;
  logic                  pin_prev;
  logic                  rtc_rise;
  logic                  pin_rise;
  logic                  pin_fall;
  logic [DATA_W-1:0]     next_rdata;

  // Peripheral divider; it stops in standby along with the timer's own clock.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      pdiv <= '0;
    end else if (!i_standby) begin
      pdiv <= pdiv + 1'b1;
    end
  end

  // Each divider tap fires once per 4, 16, 64, 256 or 1024 cycles.
  generate
    for (genvar k = 0; k < PRESCALE_N; k++) begin : g_tap
      assign div_tick[k] = &pdiv[2*k+1:0];
    end
  endgenerate

  // Edge detection of the tick and the pin; pin edges are ignored while we drive it.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rtc_prev <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      rtc_prev <= i_rtc_tick;
      pin_prev <= i_clk_pin_in;
    end
  end
  assign rtc_rise = i_rtc_tick & ~rtc_prev;
  assign pin_rise = ~pin_out_sel & i_clk_pin_in & ~pin_prev;
  assign pin_fall = ~pin_out_sel & ~i_clk_pin_in & pin_prev;

  // Pin control holds only bit zero, so the other bits can never store a one.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_out_sel <= PIN_CTRL_RST;
    end else if (i_write && i_addr == PIN_CTRL_IDX) begin
      pin_out_sel <= i_wdata[PIN_OUT_BIT];
    end
  end

  // The pin output is a registered copy of the tick, driven only when selected.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_clk_pin_out <= 1'b0;
    end else begin
      o_clk_pin_out <= i_rtc_tick;
    end
  end
  assign o_clk_pin_oe = pin_out_sel;

  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic sel;
      logic wr_any;
      assign sel    = chan_sel(i_addr, 3'(c));
      assign wr_any = i_write & sel & (i_addr[2:0] == COUNT_LO_OFS ||
                                       i_addr[2:0] == COUNT_HI_OFS);

      count_source_select u_src (
        .i_prescale    (prescale[c]),
        .i_edge        (edge_sel[c]),
        .i_div_tick    (div_tick),
        .i_rtc_rise    (rtc_rise),
        .i_pin_rise    (pin_rise),
        .i_pin_fall    (pin_fall),
        .i_standby     (i_standby),
        .o_count_event (count_event[c]),
        .o_is_rtc      (is_rtc[c])
      );

      assign underflow[c] = run[c] & count_event[c] & (count[c] == '0) & ~wr_any;

      // Run bit; standby clears it unless the channel runs from the tick.
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          run[c] <= RUN_CTRL_RST[c];
        end else if (i_standby && !is_rtc[c]) begin
          run[c] <= 1'b0;
        end else if (i_write && i_addr == RUN_CTRL_IDX) begin
          run[c] <= i_wdata[c];
        end
      end

      // Reload constant, written a half at a time.
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          reload[c] <= RELOAD_RST;
        end else if (i_write && sel && i_addr[2:0] == RELOAD_LO_OFS) begin
          reload[c][DATA_W-1:0] <= i_wdata;
        end else if (i_write && sel && i_addr[2:0] == RELOAD_HI_OFS) begin
          reload[c][CNT_W-1:DATA_W] <= i_wdata;
        end
      end

      // Counter; a software write wins over the count event of the same cycle.
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          count[c] <= COUNT_RST;
        end else if (i_write && sel && i_addr[2:0] == COUNT_LO_OFS) begin
          count[c][DATA_W-1:0] <= i_wdata;
        end else if (i_write && sel && i_addr[2:0] == COUNT_HI_OFS) begin
          count[c][CNT_W-1:DATA_W] <= i_wdata;
        end else if (underflow[c]) begin
          count[c] <= reload[c];
        end else if (run[c] && count_event[c]) begin
          count[c] <= count[c] - 1'b1;
        end
      end

      // Upper-half read freezes the lower half for the read that follows.
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          low_buf[c] <= COUNT_RST[DATA_W-1:0];
        end else if (i_read && sel && i_addr[2:0] == COUNT_HI_OFS) begin
          low_buf[c] <= count[c][DATA_W-1:0];
        end
      end

      // Control fields.
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          prescale[c] <= PRESCALE_RST;
          edge_sel[c] <= EDGE_RST;
          irq_en[c]   <= 1'b0;
        end else if (i_write && sel && i_addr[2:0] == CONTROL_OFS) begin
          prescale[c] <= i_wdata[PRESCALE_LSB +: 3];
          edge_sel[c] <= i_wdata[EDGE_LSB +: 2];
          irq_en[c]   <= i_wdata[IRQ_EN_BIT];
        end
      end

      // Flag: a new underflow wins over a clearing write in the same cycle.
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          flag[c] <= 1'b0;
        end else if (underflow[c]) begin
          flag[c] <= 1'b1;
        end else if (i_write && sel && i_addr[2:0] == CONTROL_OFS) begin
          flag[c] <= flag[c] & i_wdata[FLAG_BIT];
        end
      end

      // Interrupt request follows the flag and enable with one cycle of register.
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          o_underflow_interrupt[c] <= 1'b0;
        end else begin
          o_underflow_interrupt[c] <= flag[c] & irq_en[c];
        end
      end
    end
  endgenerate

  // Capture control exists only on the last channel.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cap_ctrl <= CAP_CTRL_RST;
    end else if (i_write && chan_sel(i_addr, 3'(CAP_CH)) && i_addr[2:0] == CONTROL_OFS) begin
      cap_ctrl <= i_wdata[CAP_CTRL_LSB +: 2];
    end
  end

  // Read mux; unmapped indexes and reserved bits read zero.
  always_comb begin
    next_rdata = '0;
    if (i_addr == PIN_CTRL_IDX) begin
      next_rdata[PIN_OUT_BIT] = pin_out_sel;
    end else if (i_addr == RUN_CTRL_IDX) begin
      next_rdata[NUM_CH-1:0] = run;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (chan_sel(i_addr, 3'(c))) begin
        case (i_addr[2:0])
          RELOAD_LO_OFS: next_rdata = reload[c][DATA_W-1:0];
          RELOAD_HI_OFS: next_rdata = reload[c][CNT_W-1:DATA_W];
          COUNT_LO_OFS:  next_rdata = low_buf[c];
          COUNT_HI_OFS:  next_rdata = count[c][CNT_W-1:DATA_W];
          CONTROL_OFS: begin
            next_rdata[FLAG_BIT]            = flag[c];
            next_rdata[IRQ_EN_BIT]          = irq_en[c];
            next_rdata[EDGE_LSB +: 2]       = edge_sel[c];
            next_rdata[PRESCALE_LSB +: 3]   = prescale[c];
            if (c == CAP_CH) begin
              next_rdata[CAP_CTRL_LSB +: 2] = cap_ctrl;
            end
          end
          default: next_rdata = '0;
        endcase
      end
    end
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else if (i_read) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= '0;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  pin_ctrl_zero_a: assert property (
    i_read && i_addr == PIN_CTRL_IDX |=> o_rdata[DATA_W-1:1] == '0)
    else $error("pin control reserved bits not zero");
  run_ctrl_zero_a: assert property (
    i_read && i_addr == RUN_CTRL_IDX |=> o_rdata[DATA_W-1:NUM_CH] == '0)
    else $error("run control reserved bits not zero");
  pin_drive_a: assert property (
    i_write && i_addr == PIN_CTRL_IDX |=> o_clk_pin_oe == $past(i_wdata[PIN_OUT_BIT]))
    else $error("pin direction did not follow write");

  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
      stopped_hold_a: assert property (
        !run[c] && !i_write |=> $stable(count[c]))
        else $error("stopped counter changed");
      reload_load_a: assert property (
        underflow[c] |=> count[c] == $past(reload[c]) && flag[c])
        else $error("underflow did not reload and flag");
      count_write_a: assert property (
        i_write && chan_sel(i_addr, 3'(c)) && i_addr[2:0] == COUNT_LO_OFS
        |=> count[c][DATA_W-1:0] == $past(i_wdata))
        else $error("counter write did not land");
      count_step_a: assert property (
        run[c] && count_event[c] && count[c] != '0 && !i_write
        |=> count[c] == $past(count[c]) - 1)
        else $error("counter did not decrement");
      standby_run_a: assert property (
        i_standby && !is_rtc[c] |=> !run[c])
        else $error("standby kept a non tick channel running");
      flag_hold_a: assert property (
        flag[c] && !(i_write && chan_sel(i_addr, 3'(c)) && i_addr[2:0] == CONTROL_OFS)
        |=> flag[c])
        else $error("flag dropped without a clearing write");
      irq_follow_a: assert property (
        ##1 o_underflow_interrupt[c] == $past(flag[c] & irq_en[c]))
        else $error("interrupt does not follow flag and enable");
      coherent_read_a: assert property (
        i_read && chan_sel(i_addr, 3'(c)) && i_addr[2:0] == COUNT_HI_OFS
        ##1 i_read && chan_sel(i_addr, 3'(c)) && i_addr[2:0] == COUNT_LO_OFS
        |=> o_rdata == $past(count[c][DATA_W-1:0], 2))
        else $error("lower half not coherent with upper read");
    end
  endgenerate
endmodule : reload_down_timer

// ### bench/pin_clock_source.sv
// Outside clock source that drives the shared timer clock pin.
`timescale 1ns/1ns
module pin_clock_source (
  input  wire logic i_core_clk,
  input  wire logic i_pin_oe,
  input  wire logic i_pin_out,
  output logic      o_pin
);
  logic level = 1'b0;

  // The device's drive wins while it enables the pin, else this source shows.
  assign o_pin = i_pin_oe ? i_pin_out : level;

  // Make n edges, gap cycles apart; the line stands still between calls.
  task automatic toggle(input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge i_core_clk);
      level <= ~level;
    end
  endtask : toggle
endmodule : pin_clock_source

// ### bench/testbench.sv
// Register-level bench for the three-channel reload down timer.
`timescale 1ns/1ns
module testbench
  import reload_timer_pkg::*;
;
  logic              i_core_clk;
  logic              i_reset;
  logic              i_standby;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic              i_write;
  logic              i_read;
  logic [DATA_W-1:0] o_rdata;
  logic              i_rtc_tick;
  logic              pin;
  logic              o_clk_pin_out;
  logic              o_clk_pin_oe;
  logic [NUM_CH-1:0] o_underflow_interrupt;
  logic [31:0]       v;
  logic [15:0]       d;
  int                n_errors;
  int                checks_done;

  reload_down_timer dut (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_standby(i_standby),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
    .o_rdata(o_rdata), .i_rtc_tick(i_rtc_tick), .i_clk_pin_in(pin),
    .o_clk_pin_out(o_clk_pin_out), .o_clk_pin_oe(o_clk_pin_oe),
    .o_underflow_interrupt(o_underflow_interrupt)
  );

  pin_clock_source src (
    .i_core_clk(i_core_clk), .i_pin_oe(o_clk_pin_oe), .i_pin_out(o_clk_pin_out), .o_pin(pin)
  );

  // Free-running 100 MHz clock.
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  function automatic logic [ADDR_W-1:0] ca(input int c, input logic [2:0] o);
    return CH_BASE_IDX + ADDR_W'(8 * c) + ADDR_W'(o);
  endfunction : ca

  // Each strobe task starts with an edge, so a strobe is never set and cleared in one step.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] w);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_wdata <= w;
    i_write <= 1'b1;
    @(posedge i_core_clk);
    i_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] r);
    @(posedge i_core_clk);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_core_clk);
    i_read <= 1'b0;
    #1;
    r = o_rdata;
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Free-running divider phase is unknown, so one count either way is accepted.
  task automatic chk_near(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (!(got === exp || got === exp - 32'h1 || got === exp + 32'h1)) begin
      n_errors++;
      $display("Error at %0t: got %h expected about %h", $time, got, exp);
    end
  endtask : chk_near

  task automatic exp_reg(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    logic [15:0] r;
    rd(a, r);
    chk({16'h0000, r}, {16'h0000, e});
  endtask : exp_reg

  // Upper half first, so the lower half comes from the coherent buffer.
  // The two reads go back to back, so the strobe stays high across both edges.
  task automatic rd_cnt(input int c, output logic [31:0] val);
    logic [15:0] h;
    @(posedge i_core_clk);
    i_addr <= ca(c, COUNT_HI_OFS);
    i_read <= 1'b1;
    @(posedge i_core_clk);
    i_addr <= ca(c, COUNT_LO_OFS);
    #1;
    h = o_rdata;
    @(posedge i_core_clk);
    i_read <= 1'b0;
    #1;
    val = {h, o_rdata};
  endtask : rd_cnt

  task automatic wr32(input int c, input logic [2:0] o, input logic [31:0] val);
    wr(ca(c, o), val[15:0]);
    wr(ca(c, o + 3'h1), val[31:16]);
  endtask : wr32

  task automatic finish_test;
    $display("Counts: %0d mismatches in %0d checks", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // Watchdog sized well above the roughly 12000 cycles the tests need.
  initial begin
    repeat (40000) @(posedge i_core_clk);
    n_errors++;
    finish_test();
  end

  // Main sequence.
  initial begin
    n_errors = 0;
    checks_done = 0;
    i_reset = 1'b1;
    i_standby = 1'b0;
    i_addr = 6'h00;
    i_wdata = 16'h0000;
    i_write = 1'b0;
    i_read = 1'b0;
    i_rtc_tick = 1'b0;
    repeat (8) @(posedge i_core_clk);
    i_reset <= 1'b0;
    exp_reg(PIN_CTRL_IDX, 16'h0000);
    exp_reg(RUN_CTRL_IDX, 16'h0000);
    for (int c = 0; c < NUM_CH; c++) begin
      exp_reg(ca(c, RELOAD_HI_OFS), RELOAD_RST[31:16]);
      exp_reg(ca(c, RELOAD_LO_OFS), RELOAD_RST[15:0]);
      rd_cnt(c, v);
      chk(v, COUNT_RST);
      exp_reg(ca(c, CONTROL_OFS), 16'h0000);
    end
    $display("Test reset values done");

    wr(PIN_CTRL_IDX, 16'h00FF);
    exp_reg(PIN_CTRL_IDX, 16'h0001);
    chk(o_clk_pin_oe, 1'b1);
    i_rtc_tick <= 1'b1;
    @(posedge i_core_clk);
    #1;
    chk(o_clk_pin_out, 1'b1);
    i_rtc_tick <= 1'b0;
    wr(PIN_CTRL_IDX, 16'h0000);
    #1;
    chk(o_clk_pin_oe, 1'b0);
    wr(RUN_CTRL_IDX, 16'hFFF8);
    exp_reg(RUN_CTRL_IDX, 16'h0000);
    wr(ca(0, CONTROL_OFS), 16'hFEFF);
    exp_reg(ca(0, CONTROL_OFS), 16'h003F);
    wr(ca(2, CONTROL_OFS), 16'hFEC0);
    exp_reg(ca(2, CONTROL_OFS), 16'h00C0);
    exp_reg(6'h3F, 16'h0000);
    $display("Test reserved bits done");

    wr(ca(1, CONTROL_OFS), 16'h0027);
    wr32(1, RELOAD_LO_OFS, 32'h2);
    wr32(1, COUNT_LO_OFS, 32'h1);
    wr(RUN_CTRL_IDX, 16'h0002);
    src.toggle(4, 3);
    repeat (4) @(posedge i_core_clk);
    rd_cnt(1, v);
    chk(v, 32'h2);
    exp_reg(ca(1, CONTROL_OFS), 16'h0127);
    chk(o_underflow_interrupt, 3'b010);
    rd(ca(1, COUNT_HI_OFS), d);
    chk({16'h0000, d}, 32'h00000000);
    src.toggle(2, 3);
    repeat (4) @(posedge i_core_clk);
    exp_reg(ca(1, COUNT_LO_OFS), 16'h0002);
    rd_cnt(1, v);
    chk(v, 32'h1);
    wr(ca(1, CONTROL_OFS), 16'h0127);
    exp_reg(ca(1, CONTROL_OFS), 16'h0127);
    wr(ca(1, CONTROL_OFS), 16'h0027);
    exp_reg(ca(1, CONTROL_OFS), 16'h0027);
    chk(o_underflow_interrupt, 3'b000);
    for (int e = 0; e < 3; e++) begin
      wr(ca(1, CONTROL_OFS), 16'h0007 | 16'(e << EDGE_LSB));
      wr32(1, COUNT_LO_OFS, 32'hA);
      src.toggle(4, 3);
      repeat (4) @(posedge i_core_clk);
      rd_cnt(1, v);
      chk(v, (e == 2) ? 32'h6 : 32'h8);
    end
    $display("Test pin counting done");

    wr(ca(2, CONTROL_OFS), 16'h0006);
    wr32(2, COUNT_LO_OFS, 32'h64);
    wr(RUN_CTRL_IDX, 16'h0006);
    i_standby <= 1'b1;
    src.toggle(4, 3);
    repeat (3) begin
      i_rtc_tick <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_rtc_tick <= 1'b0;
      repeat (2) @(posedge i_core_clk);
    end
    i_standby <= 1'b0;
    rd_cnt(2, v);
    chk(v, 32'h61);
    rd_cnt(1, v);
    chk(v, 32'h6);
    exp_reg(RUN_CTRL_IDX, 16'h0004);
    exp_reg(ca(1, CONTROL_OFS), 16'h0017);
    exp_reg(ca(1, RELOAD_LO_OFS), 16'h0002);
    wr(RUN_CTRL_IDX, 16'h0000);
    $display("Test standby done");

    // Eight periods of each divider should give eight counts; code 5 gives none.
    for (int p = 0; p < 6; p++) begin
      wr(ca(0, CONTROL_OFS), 16'(p));
      wr32(0, COUNT_LO_OFS, 32'h64);
      wr(RUN_CTRL_IDX, 16'h0001);
      repeat ((p == 5) ? 64 : (32 << (2 * p)) - 2) @(posedge i_core_clk);
      wr(RUN_CTRL_IDX, 16'h0000);
      rd_cnt(0, v);
      chk_near(v, (p == 5) ? 32'h64 : 32'h5C);
    end
    $display("Test prescale done");
    finish_test();
  end
endmodule : testbench
